// >>> logic/tbp_pkg.sv
// Constants for the timer-based PWM output block.
// Assumes byte addressing on an Avalon-MM slave with 32-bit data.
// -----------------------------------------------------------------
// Package
// -----------------------------------------------------------------
package tbp_pkg;
  // Bus shape
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  // Register byte offsets
  localparam logic [4:0] OFF_CCP_CONTROL = 5'h00;
  localparam logic [4:0] OFF_DUTY_UPPER = 5'h04;
  localparam logic [4:0] OFF_DUTY_SHADOW = 5'h08;
  localparam logic [4:0] OFF_PERIOD_COUNTER = 5'h0C;
  localparam logic [4:0] OFF_PERIOD_LIMIT = 5'h10;
  localparam logic [4:0] OFF_TIMER_CONTROL = 5'h14;
  localparam logic [4:0] OFF_STATUS = 5'h18;
  localparam logic [4:0] OFF_PIN_DIR = 5'h1C;
  // Control register fields
  localparam int unsigned CCP_DUTY_LSB = 4;
  localparam int unsigned CCP_MODE_LSB = 2;
  localparam logic [7:0] CCP_WRITE_MASK = 8'hBF;
  localparam logic [1:0] MODE_PWM = 2'h3;
  // Timer control fields
  localparam int unsigned TCON_ON_BIT = 2;
  localparam logic [1:0] PS_1 = 2'h0;
  localparam logic [1:0] PS_4 = 2'h1;
  // Status fields
  localparam int unsigned STAT_FLAG_BIT = 0;
  localparam int unsigned STAT_PIN_BIT = 1;
  // Reset values
  localparam logic [7:0] CCP_CONTROL_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] PERIOD_COUNTER_RST = 8'h00;
  localparam logic [7:0] PERIOD_LIMIT_RST = 8'hFF;
  localparam logic [2:0] TCON_RST = 3'h0;
  localparam logic PIN_DIR_RST = 1'b1;
  // Timing: four oscillator periods per count, prescale end values
  localparam logic [1:0] QUARTER_LAST = 2'h3;
  localparam logic [3:0] PRE_LAST_1 = 4'h0;
  localparam logic [3:0] PRE_LAST_4 = 4'h3;
  localparam logic [3:0] PRE_LAST_16 = 4'hF;
endpackage : tbp_pkg

// >>> logic/tbp_prescale.sv
// Prescaler and oscillator phase counter for the PWM time base.
// Assumes the caller gates i_run with enable and sleep.
`timescale 1ns/1ps
`default_nettype none
module tbp_prescale (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic i_clear,
  input wire logic [1:0] i_ps_sel,
  output logic o_tick,
  output logic [1:0] o_low2
);
  import tbp_pkg::*;

  logic [1:0] phase_q; // Oscillator phase within one count
  logic [3:0] pre_q; // Counts of four-oscillator steps
  logic [3:0] pre_last; // Wrap value for the chosen ratio

  // -----------------------------------------------------------------
  // Ratio select
  // -----------------------------------------------------------------
  // Ratios of one, four and sixteen; codes 2 and 3 both map to sixteen
  always_comb begin
    case (i_ps_sel)
      PS_1: pre_last = PRE_LAST_1;
      PS_4: pre_last = PRE_LAST_4;
      default: pre_last = PRE_LAST_16;
    endcase
  end

  // -----------------------------------------------------------------
  // Counters
  // -----------------------------------------------------------------
  // Frozen when not running, so sleep resumes exactly where it stopped
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || i_clear) begin
      phase_q <= 2'h0;
      pre_q <= 4'h0;
    end else if (i_run) begin
      phase_q <= phase_q + 2'h1;
      if (phase_q == QUARTER_LAST) begin
        pre_q <= (pre_q == pre_last) ? 4'h0 : pre_q + 4'h1;
      end
    end
  end

  // One pulse per period counter increment
  assign o_tick = i_run && (phase_q == QUARTER_LAST) && (pre_q == pre_last);

  // Low time base bits: phase at 1:1, prescaler bits otherwise
  always_comb begin
    case (i_ps_sel)
      PS_1: o_low2 = phase_q;
      PS_4: o_low2 = pre_q[1:0];
      default: o_low2 = pre_q[3:2];
    endcase
  end
endmodule : tbp_prescale
`default_nettype wire

// >>> logic/tbp_pwm_top.sv
// Single-output PWM generator with period counter and Avalon-MM slave.
// Assumes synchronous inputs on i_sys_clk and a sleep level from the core.
//
// Notes on behaviour
// - Period is (limit+1) x 4 x prescale clocks
// - Counter clears on increment after limit match
// - Rollover sets pin unless duty is zero
// - Rollover copies duty into shadow and latch
// - No postscaler in the PWM period
// - Duty is upper byte plus control bits 5:4
// - Duty writes anytime, applied after period ends
// - Shadow is read-only while PWM selected
// - Shadow plus 2-bit latch double-buffer duty
// - Time base is counter plus phase/prescaler bits
// - Time base equal to shadow duty clears pin
// - High time is duty x clock x prescale
// - Resolution grows with limit, ten bits at 255
// - Duty beyond period never clears the pin
// - Prescale ratios one, four and sixteen
// - Sleep freezes counter, state and pin level
// - Reset makes pin input and registers default
// - Pin driven only with direction bit cleared
// - Control resets zero, bit 6 reads zero
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tbp_pwm_top (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_sleep,
  input wire logic [tbp_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [tbp_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [tbp_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_pwm_pin_out,
  output logic o_pwm_pin_oe_n,
  output logic o_period_match_flag
);
  import tbp_pkg::*;

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  logic wait_q; // Waitrequest, high when idle
  logic [DATA_W-1:0] rdata_q; // Read data staged for the answer
  logic [7:0] ctl_q; // Control: config, duty low bits, mode
  logic [7:0] upper_q; // Buffered duty upper byte
  logic [7:0] shadow_q; // Duty shadow in use this period
  logic [1:0] latch_q; // Hidden low duty bits in use
  logic [7:0] tmr_q; // Period counter
  logic [7:0] pr_q; // Period limit
  logic [2:0] tcon_q; // Timer enable and prescale select
  logic flag_q; // Sticky period match flag
  logic dir_q; // Pin direction, high is input
  logic pin_q; // PWM output latch
  logic oe_n_q; // Registered output enable, low drives
  logic [DATA_W-1:0] rd_mux; // Read data selection
  logic req; // Any bus request
  logic accept; // Request completes at this edge
  logic wr_en; // Accepted write on byte lane zero
  logic pwm_mode; // Mode field selects PWM
  logic run; // Prescaler may advance
  logic tick; // Period counter increments now
  logic [1:0] low2; // Low bits of the time base
  logic rollover; // Counter at limit with an increment
  logic [9:0] duty_next; // Duty software has buffered
  logic [9:0] duty_cur; // Duty in use this period
  logic [9:0] time_base; // Counter joined with low bits
  logic hit; // Time base reached current duty
  logic set_q; // Rollover seen one clock ago; raises the pin
  logic tmr_wr; // Software writes the counter
  logic tcon_wr; // Software writes the timer control

  // -----------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------
  // Each access takes one wait cycle; reads are staged in it
  assign req = i_avs_read || i_avs_write;
  assign accept = req && !wait_q;
  assign wr_en = i_avs_write && accept && i_avs_byteenable[0];
  assign tmr_wr = wr_en && (i_avs_address == OFF_PERIOD_COUNTER);
  assign tcon_wr = wr_en && (i_avs_address == OFF_TIMER_CONTROL);

  // Waitrequest drops for exactly one cycle per request
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wait_q <= 1'b1;
    end else if (accept) begin
      wait_q <= 1'b1;
    end else if (req) begin
      wait_q <= 1'b0;
    end
  end

  // Read mux; unmapped offsets and reserved bits read zero
  always_comb begin
    rd_mux = '0;
    case (i_avs_address)
      OFF_CCP_CONTROL: rd_mux[7:0] = ctl_q & CCP_WRITE_MASK;
      OFF_DUTY_UPPER: rd_mux[7:0] = upper_q;
      OFF_DUTY_SHADOW: rd_mux[7:0] = shadow_q;
      OFF_PERIOD_COUNTER: rd_mux[7:0] = tmr_q;
      OFF_PERIOD_LIMIT: rd_mux[7:0] = pr_q;
      OFF_TIMER_CONTROL: rd_mux[2:0] = tcon_q;
      OFF_STATUS: begin
        rd_mux[STAT_FLAG_BIT] = flag_q;
        rd_mux[STAT_PIN_BIT] = pin_q;
      end
      OFF_PIN_DIR: rd_mux[0] = dir_q;
      default: rd_mux = '0;
    endcase
  end

  // Staged in the wait cycle; a value may be one clock old
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else if (i_avs_read && wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  // -----------------------------------------------------------------
  // Software registers
  // -----------------------------------------------------------------
  // Control; bit 6 is never stored
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctl_q <= CCP_CONTROL_RST;
    end else if (wr_en && (i_avs_address == OFF_CCP_CONTROL)) begin
      ctl_q <= i_avs_writedata[7:0] & CCP_WRITE_MASK;
    end
  end

  // Duty upper byte: buffered, takes effect at the next rollover
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      upper_q <= DUTY_RST;
    end else if (wr_en && (i_avs_address == OFF_DUTY_UPPER)) begin
      upper_q <= i_avs_writedata[7:0];
    end
  end

  // Period limit
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pr_q <= PERIOD_LIMIT_RST;
    end else if (wr_en && (i_avs_address == OFF_PERIOD_LIMIT)) begin
      pr_q <= i_avs_writedata[7:0];
    end
  end

  // Timer control: enable and prescale only, no postscaler path
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tcon_q <= TCON_RST;
    end else if (tcon_wr) begin
      tcon_q <= i_avs_writedata[2:0];
    end
  end

  // Direction bit; reset leaves the pin an input
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      dir_q <= PIN_DIR_RST;
    end else if (wr_en && (i_avs_address == OFF_PIN_DIR)) begin
      dir_q <= i_avs_writedata[0];
    end
  end

  // -----------------------------------------------------------------
  // Time base
  // -----------------------------------------------------------------
  assign pwm_mode = (ctl_q[CCP_MODE_LSB +: 2] == MODE_PWM);
  assign run = tcon_q[TCON_ON_BIT] && !i_sleep;

  // Writing the counter or its control restarts the prescaler
  tbp_prescale tbp_prescale_inst (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_run(run),
    .i_clear(tmr_wr || tcon_wr),
    .i_ps_sel(tcon_q[1:0]),
    .o_tick(tick),
    .o_low2(low2)
  );

  // Period ends on the increment after counter reaches the limit
  assign rollover = tick && (tmr_q == pr_q);

  // Period counter; a software write wins over counting
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tmr_q <= PERIOD_COUNTER_RST;
    end else if (tmr_wr) begin
      tmr_q <= i_avs_writedata[7:0];
    end else if (rollover) begin
      tmr_q <= 8'h00;
    end else if (tick) begin
      tmr_q <= tmr_q + 8'h01;
    end
  end

  // -----------------------------------------------------------------
  // Duty double buffer
  // -----------------------------------------------------------------
  assign duty_next = {upper_q, ctl_q[CCP_DUTY_LSB +: 2]};
  assign duty_cur = {shadow_q, latch_q};
  assign time_base = {tmr_q, low2};
  // Short limits leave upper duty codes unreachable
  assign hit = (time_base == duty_cur);

  // Shadow loads only at rollover in PWM, so no mid-period glitch
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      shadow_q <= DUTY_RST;
      latch_q <= 2'h0;
    end else if (pwm_mode && rollover) begin
      shadow_q <= duty_next[9:2];
      latch_q <= duty_next[1:0];
    end else if (!pwm_mode && wr_en && (i_avs_address == OFF_DUTY_SHADOW)) begin
      shadow_q <= i_avs_writedata[7:0];
    end
  end

  // -----------------------------------------------------------------
  // Output latch
  // -----------------------------------------------------------------
  // Pin rises one clock after rollover, so the registered match clear
  // gives a high time of exactly duty steps; sleep holds the pending set
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      set_q <= 1'b0;
    end else if (i_sleep) begin
      set_q <= set_q;
    end else begin
      set_q <= pwm_mode && rollover;
    end
  end

  // Leaving PWM drops the latch; sleep holds it; a pending set beats match
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pin_q <= 1'b0;
    end else if (!pwm_mode) begin
      pin_q <= 1'b0;
    end else if (i_sleep) begin
      pin_q <= pin_q;
    end else if (set_q) begin
      pin_q <= (duty_cur != 10'h000);
    end else if (hit) begin
      // High time is duty steps of one clock times prescale
      pin_q <= 1'b0;
    end
    // Duty past the period never hits, so the latch stays put
  end

  // Driver enabled only when the direction bit is cleared
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= dir_q || !pwm_mode;
    end
  end

  // -----------------------------------------------------------------
  // Period match flag
  // -----------------------------------------------------------------
  // Write one to clear; a match in the same cycle keeps it set
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      flag_q <= 1'b0;
    end else if (rollover) begin
      flag_q <= 1'b1;
    end else if (wr_en && (i_avs_address == OFF_STATUS) && i_avs_writedata[STAT_FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_pwm_pin_out = pin_q;
  assign o_pwm_pin_oe_n = oe_n_q;
  assign o_period_match_flag = flag_q;

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_roll;
    rollover && !tmr_wr;
  endsequence

  sequence s_pwm_roll;
    pwm_mode && rollover && !i_sleep;
  endsequence

  sequence s_shadow_write;
    pwm_mode && wr_en && (i_avs_address == OFF_DUTY_SHADOW) && !rollover;
  endsequence

  a_wrap_to_zero:
    assert property (s_roll |=> (tmr_q == 8'h00))
      else $error("counter did not clear after limit match");

  a_flag_on_roll:
    assert property (rollover |=> flag_q[*2] or (flag_q ##1 !flag_q))
      else $error("match flag not set at rollover");

  a_pin_set_roll:
    assert property (s_pwm_roll ##0 (duty_next != 10'h000) ##1 (pwm_mode && !i_sleep) |=> pin_q)
      else $error("pin not set at rollover");

  a_zero_duty_low:
    assert property (s_pwm_roll ##0 (duty_next == 10'h000) ##1 (pwm_mode && !i_sleep) |=> !pin_q)
      else $error("zero duty raised the pin");

  a_shadow_loads:
    assert property (s_pwm_roll |=> ({shadow_q, latch_q} == $past(duty_next)))
      else $error("shadow not loaded at rollover");

  a_match_clears:
    assert property (pwm_mode && !i_sleep && !set_q && hit |=> !pin_q)
      else $error("duty match did not clear pin");

  a_sleep_freeze:
    assert property (i_sleep && !wr_en |=> $stable(tmr_q) && $stable(pin_q) && $stable(shadow_q))
      else $error("state changed during sleep");

  a_dir_gates_oe:
    assert property (dir_q |=> o_pwm_pin_oe_n)
      else $error("pin driven with direction set to input");

  a_shadow_ro:
    assert property (s_shadow_write |=> $stable(shadow_q))
      else $error("shadow written while in PWM");

  a_bus_one_wait:
    assert property (req && wait_q |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("waitrequest not low for exactly one cycle");
endmodule : tbp_pwm_top
`default_nettype wire

// >>> verif/tbp_load_model.sv
// Load model for the PWM pin: a pull-down resistor plus a pulse timer.
// Assumes the pin changes only on rising edges of i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
module tbp_load_model (
  input wire logic i_sys_clk,
  input wire logic i_pin_out,
  input wire logic i_pin_oe_n,
  output logic o_level,
  output logic [15:0] o_high_len,
  output logic [15:0] o_period_len,
  output logic [15:0] o_rises
);
  // Previous level and running counts
  logic prev_q = 1'b0;
  logic [15:0] cnt_q = 16'h0000;
  logic [15:0] hcnt_q = 16'h0000;
  logic [15:0] high_q = 16'h0000;
  logic [15:0] period_q = 16'h0000;
  logic [15:0] rises_q = 16'h0000;
  // The pull-down wins when the driver is off, so a released pin never shows a stale high
  assign o_level = i_pin_oe_n ? 1'b0 : i_pin_out;
  assign o_high_len = high_q;
  assign o_period_len = period_q;
  assign o_rises = rises_q;
  // Measures rise-to-rise and high time in clocks
  always @(posedge i_sys_clk) begin
    prev_q <= o_level;
    if (o_level && !prev_q) begin
      period_q <= cnt_q;
      rises_q <= rises_q + 16'h0001;
      cnt_q <= 16'h0001;
      hcnt_q <= 16'h0001;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      if (o_level) begin
        hcnt_q <= hcnt_q + 16'h0001;
      end
      if (!o_level && prev_q) begin
        high_q <= hcnt_q;
      end
    end
  end
endmodule : tbp_load_model
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the PWM block, its Avalon slave and the pin load.
// Assumes a 20 MHz clock and the byte offsets of the package.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tbp_pkg::*;
  // -----------------------------------------------------------------
  // Signals
  // -----------------------------------------------------------------
  localparam int LIMIT = 40000; // Cycle ceiling, well above the run
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_sleep = 1'b0;
  logic [ADDR_W-1:0] i_avs_address = '0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [DATA_W-1:0] i_avs_writedata = '0;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic [DATA_W-1:0] o_avs_readdata;
  logic o_avs_waitrequest, o_pwm_pin_out, o_pwm_pin_oe_n, o_period_match_flag;
  logic level;
  logic [15:0] high_len, period_len, rises;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  // 50 ns clock
  always #25 i_sys_clk = ~i_sys_clk;
  tbp_pwm_top tbp_pwm_top_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sleep(i_sleep),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_pwm_pin_out(o_pwm_pin_out), .o_pwm_pin_oe_n(o_pwm_pin_oe_n),
    .o_period_match_flag(o_period_match_flag));
  tbp_load_model tbp_load_model_inst (.i_sys_clk(i_sys_clk), .i_pin_out(o_pwm_pin_out),
    .i_pin_oe_n(o_pwm_pin_oe_n), .o_level(level), .o_high_len(high_len),
    .o_period_len(period_len), .o_rises(rises));
  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  // Hang guard
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // One Avalon transfer; the request stands until waitrequest is sampled low at a rising edge
  task automatic bus(input logic is_wr, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be,
                     output logic [31:0] rd);
    @(posedge i_sys_clk);
    i_avs_address <= a;
    i_avs_write <= is_wr;
    i_avs_read <= !is_wr;
    i_avs_writedata <= {24'h000000, d};
    i_avs_byteenable <= be;
    // No local limit: only the cycle ceiling ends a hung wait
    do begin
      @(posedge i_sys_clk);
    end while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, 4'hF, rd);
  endtask : wr
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 8'h00, 4'hF, rd);
    check(rd, exp);
  endtask : rd_chk
  // Bounded wait for the sticky match flag
  task automatic wait_flag;
    int n;
    n = 0;
    while (o_period_match_flag !== 1'b1 && n < 2000) begin
      @(posedge i_sys_clk);
      n++;
    end
    check(o_period_match_flag, 1'b1);
  endtask : wait_flag
  // Full PWM setup with the driver held off until a new cycle starts
  task automatic cfg(input logic [7:0] lim, input logic [7:0] up, input logic [1:0] dc, input logic [1:0] ps);
    wr(OFF_TIMER_CONTROL, 8'h00);
    wr(OFF_PIN_DIR, 8'h01);
    wr(OFF_PERIOD_LIMIT, lim);
    wr(OFF_DUTY_UPPER, up);
    wr(OFF_CCP_CONTROL, {2'b00, dc, MODE_PWM, 2'b00});
    wr(OFF_PERIOD_COUNTER, 8'h00);
    wr(OFF_STATUS, 8'h01);
    wr(OFF_TIMER_CONTROL, {5'h00, 1'b1, ps});
    wait_flag();
    wr(OFF_PIN_DIR, 8'h00);
  endtask : cfg
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] rd;
    rd_chk(OFF_CCP_CONTROL, CCP_CONTROL_RST);
    rd_chk(OFF_DUTY_UPPER, DUTY_RST);
    rd_chk(OFF_DUTY_SHADOW, DUTY_RST);
    rd_chk(OFF_PERIOD_COUNTER, PERIOD_COUNTER_RST);
    rd_chk(OFF_PERIOD_LIMIT, PERIOD_LIMIT_RST);
    rd_chk(OFF_TIMER_CONTROL, TCON_RST);
    rd_chk(OFF_PIN_DIR, PIN_DIR_RST);
    check(o_pwm_pin_oe_n, 1'b1);
    wr(5'h02, 8'hFF);
    rd_chk(5'h02, 32'h0);
    wr(OFF_CCP_CONTROL, 8'hFF);
    rd_chk(OFF_CCP_CONTROL, CCP_WRITE_MASK);
    wr(OFF_CCP_CONTROL, 8'h00);
    bus(1'b1, OFF_PERIOD_LIMIT, 8'h55, 4'hE, rd);
    rd_chk(OFF_PERIOD_LIMIT, PERIOD_LIMIT_RST);
  endtask : t_reset
  // Period and high time seen on the loaded pin
  task automatic t_pwm(input logic [7:0] lim, input logic [7:0] up, input logic [1:0] dc, input logic [1:0] ps,
                       input logic [15:0] per, input logic [15:0] hi);
    cfg(lim, up, dc, ps);
    repeat (3 * per + 8) @(posedge i_sys_clk);
    check(period_len, per);
    check(high_len, hi);
  endtask : t_pwm
  // Shadow keeps the old duty until rollover and refuses writes
  task automatic t_shadow;
    wr(OFF_TIMER_CONTROL, 8'h00);
    wr(OFF_DUTY_UPPER, 8'h02);
    rd_chk(OFF_DUTY_SHADOW, 32'h01);
    wr(OFF_DUTY_SHADOW, 8'h77);
    rd_chk(OFF_DUTY_SHADOW, 32'h01);
    wr(OFF_STATUS, 8'h01);
    wr(OFF_TIMER_CONTROL, 8'h06);
    wait_flag();
    rd_chk(OFF_DUTY_SHADOW, 32'h02);
  endtask : t_shadow
  // Zero duty never rises; duty beyond the period never falls
  task automatic t_edge(input logic [7:0] up, input logic exp);
    logic [15:0] r;
    cfg(8'h01, up, 2'h0, PS_1);
    repeat (40) @(posedge i_sys_clk);
    r = rises;
    repeat (40) @(posedge i_sys_clk);
    check(rises, r);
    check(level, exp);
  endtask : t_edge
  // Sleep freezes counter and pin, wake resumes counting
  task automatic t_sleep;
    logic [31:0] c1, c2, c3;
    logic lv;
    // Short duty: without the freeze the pin would fall during the sleep
    cfg(8'hFF, 8'h10, 2'h0, PS_1);
    repeat (50) @(posedge i_sys_clk);
    i_sleep <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    lv = level;
    check(lv, 1'b1);
    bus(1'b0, OFF_PERIOD_COUNTER, 8'h00, 4'hF, c1);
    repeat (200) @(posedge i_sys_clk);
    bus(1'b0, OFF_PERIOD_COUNTER, 8'h00, 4'hF, c2);
    check(c2, c1);
    check(level, lv);
    i_sleep <= 1'b0;
    repeat (200) @(posedge i_sys_clk);
    bus(1'b0, OFF_PERIOD_COUNTER, 8'h00, 4'hF, c3);
    check(c3 !== c1, 1'b1);
    check(level, 1'b0);
  endtask : t_sleep
  // Direction bit, flag clear, mode off and a reset in mid-run
  task automatic t_misc;
    logic [31:0] rd;
    wr(OFF_PIN_DIR, 8'h01);
    repeat (3) @(posedge i_sys_clk);
    check(o_pwm_pin_oe_n, 1'b1);
    wr(OFF_TIMER_CONTROL, 8'h00);
    bus(1'b0, OFF_STATUS, 8'h00, 4'hF, rd);
    check(rd[STAT_FLAG_BIT], 1'b1);
    wr(OFF_STATUS, 8'h01);
    bus(1'b0, OFF_STATUS, 8'h00, 4'hF, rd);
    check(rd[STAT_FLAG_BIT], 1'b0);
    wr(OFF_PIN_DIR, 8'h00);
    wr(OFF_CCP_CONTROL, 8'h00);
    repeat (3) @(posedge i_sys_clk);
    check({o_pwm_pin_out, o_pwm_pin_oe_n}, 2'b01);
    cfg(8'h01, 8'h01, 2'h0, PS_1);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    check({o_pwm_pin_out, o_pwm_pin_oe_n, o_period_match_flag}, 3'b010);
    rd_chk(OFF_PIN_DIR, PIN_DIR_RST);
    rd_chk(OFF_CCP_CONTROL, CCP_CONTROL_RST);
  endtask : t_misc
  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    t_reset();
    t_pwm(8'h01, 8'h00, 2'h3, PS_1, 16'd8, 16'd3);
    t_pwm(8'h03, 8'h01, 2'h1, PS_1, 16'd16, 16'd5);
    t_pwm(8'h01, 8'h01, 2'h0, PS_4, 16'd32, 16'd16);
    t_pwm(8'h01, 8'h01, 2'h0, 2'h2, 16'd128, 16'd64);
    t_shadow();
    t_edge(8'h00, 1'b0);
    t_edge(8'h03, 1'b1);
    t_sleep();
    t_misc();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
